// file: design/ipc_pkg.sv
// Purpose: Constants for the interrupt and power control register bank
// Assumes: Indexed 8-bit register access, one system clock
// Notes: Offsets are register indices behind the index/data port
package ipc_pkg;
    localparam logic [7:0] IDX_IRQ_EN_MASK = 8'h19;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h1A;
    localparam logic [7:0] IDX_USR_STATUS = 8'h1C;
    localparam logic [7:0] IDX_USR_EN_MASK = 8'h1F;
    localparam logic [7:0] IDX_PWR_PIN = 8'h20;
    localparam logic [7:0] IDX_BLK_DIS = 8'h21;
    localparam logic [7:0] IDX_PANEL_SEL = 8'h22;
    localparam logic [7:0] RST_IRQ_EN_MASK = 8'h00;
    localparam logic [7:0] RST_PWR_PIN = 8'h04;
    localparam logic [7:0] RST_BLK_DIS = 8'h00;
    localparam logic [7:0] RST_PANEL_SEL = 8'h00;
    localparam logic [7:0] RST_USR_EN_MASK = 8'h00;
    localparam logic [7:0] MASK_IRQ_EN_MASK = 8'h77;
    localparam logic [7:0] MASK_PANEL_SEL = 8'h3F;
    // Interrupt enable/mask field positions
    localparam int B_EN_BM = 6;
    localparam int B_EN_VP = 5;
    localparam int B_EN_DE = 4;
    localparam int B_MK_BM = 2;
    localparam int B_MK_VP = 1;
    localparam int B_MK_DE = 0;
    // Status positions
    localparam int B_ST_LEG = 4;
    localparam int B_ST_BM = 2;
    localparam int B_ST_VP = 1;
    localparam int B_ST_DE = 0;
    // User pin fields
    localparam int USR_N = 4;
    localparam int B_USR_HW = 4;
    // Power pin control fields
    localparam int B_LP_MODE = 7;
    localparam int B_REFRESH = 6;
    localparam int B_DIV_HI = 5;
    localparam int B_DIV_LO = 4;
    localparam int B_LINK_TRI = 3;
    localparam int B_VID_TRI = 2;
    localparam int B_PNL_TRI = 1;
    localparam int B_MEM_TRI = 0;
    // Block disable fields
    localparam int B_DAC = 7;
    localparam int B_PLL = 6;
    localparam int B_LCDW = 5;
    localparam int B_LCDR = 4;
    localparam int B_PAL = 3;
    localparam int B_VIP = 2;
    localparam int B_DRAW = 1;
    localparam int B_VPROC = 0;
    // Panel select fields
    localparam int B_SYNC_HI = 5;
    localparam int B_SYNC_LO = 4;
    localparam int B_PNL_EN = 3;
    localparam int B_BIAS_EN = 2;
    // Sequencer pin value positions
    localparam int B_SEQ_PNL = 0;
    localparam int B_SEQ_BIAS = 1;
    // Pin synchroniser reset: no power-down request, strap taken as low
    localparam logic [1:0] RST_PIN_SYNC = 2'h2;
    // Clock divide codes
    localparam logic [1:0] DIV_NONE = 2'h0;
    localparam logic [1:0] DIV_4 = 2'h1;
    localparam logic [1:0] DIV_8 = 2'h2;
    localparam logic [1:0] DIV_16 = 2'h3;
    localparam logic [4:0] RATIO_1 = 5'h01;
    localparam logic [4:0] RATIO_4 = 5'h04;
    localparam logic [4:0] RATIO_8 = 5'h08;
    localparam logic [4:0] RATIO_16 = 5'h10;
    // Power states
    typedef enum logic [2:0] {
        IPC_RUN = 3'h1,
        IPC_STANDBY = 3'h2,
        IPC_SLEEP = 3'h4
    } ipc_pwr_e;
endpackage : ipc_pkg

// file: design/ipc_sync2.sv
// Purpose: Two-flop synchroniser for a bus of pin levels
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module ipc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // Two stages to settle metastability
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule : ipc_sync2
`default_nettype wire

// file: design/ipc_regs.sv
// Purpose: Interrupt and power-down control register bank
// Assumes: Indexed 8-bit accesses with one-cycle strobes on ref_clk_in
// Notes: Gated blocks and panel sequencer live elsewhere
// Summary of operation
// - Separate enable and mask bits per source
// - Mask suppresses; enabled unmasked event interrupts
// - Status shows legacy, bus master, video, draw
// - Legacy interrupt gated by legacy block bits
// - User pin status in bits three to zero
// - User pin hardware enables high, masks low
// - Power registers run on system clock only
// - Standby or sleep, only while pin low
// - Sleep picks auto or self refresh
// - Low-power clock divide by 4/8/16, 16 in sleep only
// - Link clock tri-state only with strap high
// - Video output tri-state, auto during capture
// - Panel and memory interface tri-states
// - DAC power off and PLL stop
// - LCD write FIFO off, request withdrawn
// - LCD read FIFOs, dithering off
// - Palette off by bit or low power
// - Video input port off, request withdrawn
// - Draw engine and video processor off
// - Sync power states encoding
// - Panel and bias pins, ignored under sequencer
`timescale 1ns/10ps
`default_nettype none
module ipc_regs (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_index_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic draw_engine_event_in,
    input wire logic video_port_event_in,
    input wire logic bus_master_event_in,
    input wire logic legacy_irq_in,
    input wire logic [3:0] user_pin_in,
    input wire logic power_down_request_pin_n_in,
    input wire logic external_clock_strap_in,
    input wire logic capture_enable_in,
    input wire logic panel_sequencer_en_in,
    input wire logic [7:0] panel_pin_ctl_in,
    output logic irq_out,
    output logic standby_out,
    output logic sleep_out,
    output logic self_refresh_out,
    output logic [4:0] clock_divide_out,
    output logic link_clock_oe_out,
    output logic video_out_oe_out,
    output logic video_blank_oe_out,
    output logic panel_out_oe_out,
    output logic memory_if_oe_out,
    output logic dac_power_off_out,
    output logic pll_stop_out,
    output logic lcd_write_off_out,
    output logic lcd_read_off_out,
    output logic palette_off_out,
    output logic video_input_off_out,
    output logic draw_engine_off_out,
    output logic video_processor_off_out,
    output logic hsync_stop_out,
    output logic vsync_stop_out,
    output logic panel_enable_pin_out,
    output logic panel_bias_enable_pin_out
);
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [3:0] usr_sync;
    logic [1:0] pin_sync;
    logic power_down_request_pin_n;
    logic strap;
    logic [7:0] irq_en_mask_ff;
    logic [7:0] usr_en_mask_ff;
    logic [7:0] pwr_pin_ff;
    logic [7:0] blk_dis_ff;
    logic [7:0] panel_sel_ff;
    logic [2:0] src_stat_ff;
    logic [3:0] usr_stat_ff;
    logic [7:0] irq_status;
    logic [7:0] usr_status;
    ipc_pkg::ipc_pwr_e pwr_ff;
    ipc_pkg::ipc_pwr_e nxt_pwr;
    logic [2:0] src_evt;
    logic [2:0] src_en;
    logic [2:0] src_mk;
    logic [4:0] nxt_div;
    logic [7:0] nxt_rdata;

    // Reset release through two flops so deassertion is clean
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Pins come from outside the clock domain
    ipc_sync2 #(.W(4)) u_usr_sync (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .d_in(user_pin_in),
        .q_out(usr_sync)
    );
    // Reset to the idle pin levels so no false low-power entry follows reset
    ipc_sync2 #(.W(2), .RST_VAL(ipc_pkg::RST_PIN_SYNC)) u_pin_sync (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .d_in({power_down_request_pin_n_in, external_clock_strap_in}),
        .q_out(pin_sync)
    );
    assign power_down_request_pin_n = pin_sync[1];
    assign strap = pin_sync[0];

    // Writable registers, all on the system clock so PLL-off access works
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_mask_ff <= ipc_pkg::RST_IRQ_EN_MASK;
            usr_en_mask_ff <= ipc_pkg::RST_USR_EN_MASK;
            pwr_pin_ff <= ipc_pkg::RST_PWR_PIN;
            blk_dis_ff <= ipc_pkg::RST_BLK_DIS;
            panel_sel_ff <= ipc_pkg::RST_PANEL_SEL;
        end else if (reg_wr_in) begin
            unique case (reg_index_in)
                ipc_pkg::IDX_IRQ_EN_MASK: irq_en_mask_ff <= reg_wdata_in & ipc_pkg::MASK_IRQ_EN_MASK;
                ipc_pkg::IDX_USR_EN_MASK: usr_en_mask_ff <= reg_wdata_in;
                ipc_pkg::IDX_PWR_PIN: pwr_pin_ff <= reg_wdata_in;
                ipc_pkg::IDX_BLK_DIS: blk_dis_ff <= reg_wdata_in;
                ipc_pkg::IDX_PANEL_SEL: panel_sel_ff <= reg_wdata_in & ipc_pkg::MASK_PANEL_SEL;
                default: ;
            endcase
        end
    end

    // Per-source enable and mask bits
    assign src_evt = {bus_master_event_in, video_port_event_in, draw_engine_event_in};
    assign src_en = {irq_en_mask_ff[ipc_pkg::B_EN_BM], irq_en_mask_ff[ipc_pkg::B_EN_VP],
                     irq_en_mask_ff[ipc_pkg::B_EN_DE]};
    assign src_mk = {irq_en_mask_ff[ipc_pkg::B_MK_BM], irq_en_mask_ff[ipc_pkg::B_MK_VP],
                     irq_en_mask_ff[ipc_pkg::B_MK_DE]};

    // Sticky status; an event in a clear cycle wins. Reading clears.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            src_stat_ff <= 3'h0;
        end else begin
            src_stat_ff <= (reg_rd_in && reg_index_in == ipc_pkg::IDX_IRQ_STATUS ? 3'h0 : src_stat_ff)
                           | (src_evt & src_en);
        end
    end

    // User pins latch when hardware-enabled
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            usr_stat_ff <= 4'h0;
        end else begin
            usr_stat_ff <= (reg_rd_in && reg_index_in == ipc_pkg::IDX_USR_STATUS ? 4'h0 : usr_stat_ff)
                           | (usr_sync & usr_en_mask_ff[ipc_pkg::B_USR_HW +: ipc_pkg::USR_N]);
        end
    end

    // Legacy interrupt is already gated in its own block
    assign irq_status = {3'h0, legacy_irq_in, 1'b0, src_stat_ff};
    assign usr_status = {4'h0, usr_stat_ff};

    // Single interrupt line: masks suppress, legacy passes as gated upstream
    assign irq_out = (|(src_stat_ff & ~src_mk)) | legacy_irq_in
                     | (|(usr_stat_ff & ~usr_en_mask_ff[ipc_pkg::USR_N-1:0]));

    // Read mux; data come from a flop
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (reg_index_in)
            ipc_pkg::IDX_IRQ_EN_MASK: nxt_rdata = irq_en_mask_ff;
            ipc_pkg::IDX_IRQ_STATUS: nxt_rdata = irq_status;
            ipc_pkg::IDX_USR_STATUS: nxt_rdata = usr_status;
            ipc_pkg::IDX_USR_EN_MASK: nxt_rdata = usr_en_mask_ff;
            ipc_pkg::IDX_PWR_PIN: nxt_rdata = pwr_pin_ff;
            ipc_pkg::IDX_BLK_DIS: nxt_rdata = blk_dis_ff;
            ipc_pkg::IDX_PANEL_SEL: nxt_rdata = panel_sel_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= nxt_rdata;
        end
    end

    // Low-power state follows the pin; mode bit picks which
    always_comb begin
        nxt_pwr = ipc_pkg::IPC_RUN;
        if (!power_down_request_pin_n) begin
            nxt_pwr = pwr_pin_ff[ipc_pkg::B_LP_MODE] ? ipc_pkg::IPC_SLEEP : ipc_pkg::IPC_STANDBY;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ff <= ipc_pkg::IPC_RUN;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    // Divider ratio; divide-by-16 is refused in standby and falls back to none
    always_comb begin
        nxt_div = ipc_pkg::RATIO_1;
        unique case (pwr_pin_ff[ipc_pkg::B_DIV_HI:ipc_pkg::B_DIV_LO])
            ipc_pkg::DIV_NONE: nxt_div = ipc_pkg::RATIO_1;
            ipc_pkg::DIV_4: nxt_div = ipc_pkg::RATIO_4;
            ipc_pkg::DIV_8: nxt_div = ipc_pkg::RATIO_8;
            ipc_pkg::DIV_16: nxt_div = (pwr_ff == ipc_pkg::IPC_SLEEP) ? ipc_pkg::RATIO_16 : ipc_pkg::RATIO_1;
        endcase
        if (pwr_ff == ipc_pkg::IPC_RUN) begin
            nxt_div = ipc_pkg::RATIO_1;
        end
    end

    // Registered power and gating outputs
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            standby_out <= 1'b0;
            sleep_out <= 1'b0;
            self_refresh_out <= 1'b0;
            clock_divide_out <= ipc_pkg::RATIO_1;
            palette_off_out <= 1'b0;
        end else begin
            standby_out <= (pwr_ff == ipc_pkg::IPC_STANDBY);
            sleep_out <= (pwr_ff == ipc_pkg::IPC_SLEEP);
            self_refresh_out <= (pwr_ff == ipc_pkg::IPC_SLEEP) && pwr_pin_ff[ipc_pkg::B_REFRESH];
            clock_divide_out <= nxt_div;
            palette_off_out <= blk_dis_ff[ipc_pkg::B_PAL] || (pwr_ff != ipc_pkg::IPC_RUN);
        end
    end

    // Pin enables; strap low makes the shared pin an input
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            link_clock_oe_out <= 1'b0;
            video_out_oe_out <= 1'b0;
            video_blank_oe_out <= 1'b0;
            panel_out_oe_out <= 1'b0;
            memory_if_oe_out <= 1'b0;
        end else begin
            link_clock_oe_out <= strap && !pwr_pin_ff[ipc_pkg::B_LINK_TRI];
            video_out_oe_out <= !pwr_pin_ff[ipc_pkg::B_VID_TRI] && !capture_enable_in;
            video_blank_oe_out <= !pwr_pin_ff[ipc_pkg::B_VID_TRI];
            panel_out_oe_out <= !pwr_pin_ff[ipc_pkg::B_PNL_TRI];
            memory_if_oe_out <= !pwr_pin_ff[ipc_pkg::B_MEM_TRI];
        end
    end

    // Block disables straight from the register
    assign dac_power_off_out = blk_dis_ff[ipc_pkg::B_DAC];
    assign pll_stop_out = blk_dis_ff[ipc_pkg::B_PLL];
    assign lcd_write_off_out = blk_dis_ff[ipc_pkg::B_LCDW];
    assign lcd_read_off_out = blk_dis_ff[ipc_pkg::B_LCDR];
    assign video_input_off_out = blk_dis_ff[ipc_pkg::B_VIP];
    assign draw_engine_off_out = blk_dis_ff[ipc_pkg::B_DRAW];
    assign video_processor_off_out = blk_dis_ff[ipc_pkg::B_VPROC];

    // Sync states: high bit stops vertical, low bit stops horizontal
    assign vsync_stop_out = panel_sel_ff[ipc_pkg::B_SYNC_HI];
    assign hsync_stop_out = panel_sel_ff[ipc_pkg::B_SYNC_LO];

    // Sequencer owns the panel pins when enabled
    assign panel_enable_pin_out = panel_sequencer_en_in ? panel_pin_ctl_in[ipc_pkg::B_SEQ_PNL]
                                  : panel_sel_ff[ipc_pkg::B_PNL_EN];
    assign panel_bias_enable_pin_out = panel_sequencer_en_in ? panel_pin_ctl_in[ipc_pkg::B_SEQ_BIAS]
                                       : panel_sel_ff[ipc_pkg::B_BIAS_EN];

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    mask_blocks_a: assert property (src_stat_ff[0] && src_mk[0] && !legacy_irq_in && !(|usr_stat_ff)
        && !(|(src_stat_ff[2:1] & ~src_mk[2:1])) |-> !irq_out) else $error("masked source drove irq");
    status_sets_a: assert property (draw_engine_event_in && src_en[0] |=> src_stat_ff[0])
        else $error("draw event not latched");
    disabled_src_a: assert property (!src_en[1] && !src_stat_ff[1] && !(reg_rd_in) |=> !src_stat_ff[1])
        else $error("disabled source latched");
    run_no_div_a: assert property (pwr_ff == ipc_pkg::IPC_RUN |=> clock_divide_out == ipc_pkg::RATIO_1)
        else $error("divide in run");
    sleep_entry_a: assert property ($fell(power_down_request_pin_n) && pwr_pin_ff[ipc_pkg::B_LP_MODE]
        && $stable(pwr_pin_ff) |-> ##2 sleep_out) else $error("sleep not entered");
    palette_lp_a: assert property (pwr_ff != ipc_pkg::IPC_RUN |=> palette_off_out)
        else $error("palette on in low power");
    strap_link_a: assert property (!strap |=> !link_clock_oe_out) else $error("link clock driven");
    capture_float_a: assert property (capture_enable_in |=> !video_out_oe_out)
        else $error("video out driven in capture");
    panel_direct_a: assert property (!panel_sequencer_en_in
        |-> panel_enable_pin_out == panel_sel_ff[ipc_pkg::B_PNL_EN])
        else $error("panel pin mismatch");
    self_ref_a: assert property (self_refresh_out |-> sleep_out) else $error("self refresh outside sleep");

    cov_sleep_c: cover property (sleep_out ##1 self_refresh_out);
    cov_standby_c: cover property (standby_out && clock_divide_out == ipc_pkg::RATIO_8);
    cov_irq_c: cover property (!irq_out ##1 irq_out);
    cov_usr_c: cover property (|usr_stat_ff);
endmodule : ipc_regs
`default_nettype wire

// file: test/test_ipc_regs.sv
// Purpose: Self-checking bench for the interrupt and power control register bank
// Assumes: Indexed strobe access, one 100 MHz clock, pins driven by the bench
// Notes: Fixed waits cover the two-flop pin synchronisers plus up to two register stages
`timescale 1ns/10ps
`default_nettype none
module test_ipc_regs;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] idx = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdata;
    logic de_ev = 1'b0;
    logic vp_ev = 1'b0;
    logic bm_ev = 1'b0;
    logic leg = 1'b0;
    logic [3:0] usr = 4'h0;
    logic pd_n = 1'b1;
    logic strap = 1'b1;
    logic cap = 1'b0;
    logic seq_en = 1'b0;
    logic [7:0] pctl = 8'h00;
    logic irq, stby, slp, sref, voe, boe, poe, moe, loe;
    logic dac, pll, lw, lr, pal, vip, drw, vpr, hs, vs, pe, pb;
    logic [4:0] div;
    int num_errors = 0;
    int samples_checked = 0;
    logic [4:0] ratio [4];
    int c;

    ipc_regs dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_index_in(idx), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_wdata_in(wd), .reg_rdata_out(rdata), .draw_engine_event_in(de_ev),
        .video_port_event_in(vp_ev), .bus_master_event_in(bm_ev), .legacy_irq_in(leg), .user_pin_in(usr),
        .power_down_request_pin_n_in(pd_n), .external_clock_strap_in(strap), .capture_enable_in(cap),
        .panel_sequencer_en_in(seq_en), .panel_pin_ctl_in(pctl), .irq_out(irq), .standby_out(stby),
        .sleep_out(slp), .self_refresh_out(sref), .clock_divide_out(div), .link_clock_oe_out(loe),
        .video_out_oe_out(voe), .video_blank_oe_out(boe), .panel_out_oe_out(poe), .memory_if_oe_out(moe),
        .dac_power_off_out(dac), .pll_stop_out(pll), .lcd_write_off_out(lw), .lcd_read_off_out(lr),
        .palette_off_out(pal), .video_input_off_out(vip), .draw_engine_off_out(drw),
        .video_processor_off_out(vpr), .hsync_stop_out(hs), .vsync_stop_out(vs),
        .panel_enable_pin_out(pe), .panel_bias_enable_pin_out(pb));

    // Free-running 100 MHz system clock
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : tick

    // One-cycle write strobe; index and data held through the taking edge
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge ref_clk_in);
        idx <= i;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk_in);
        wr_s <= 1'b0;
    endtask : wr

    // Read data lands on the taking edge, so it is sampled just after it
    task automatic rd(input logic [7:0] i, input logic [7:0] exp);
        @(posedge ref_clk_in);
        idx <= i;
        rd_s <= 1'b1;
        @(posedge ref_clk_in);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd

    task automatic ev(input logic [2:0] m);
        @(posedge ref_clk_in);
        {bm_ev, vp_ev, de_ev} <= m;
        @(posedge ref_clk_in);
        {bm_ev, vp_ev, de_ev} <= 3'h0;
    endtask : ev

    task automatic pin(input logic [3:0] p);
        @(posedge ref_clk_in);
        usr <= p;
        tick(4);
        @(posedge ref_clk_in) usr <= 4'h0;
        tick(4);
    endtask : pin

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        num_errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        ratio = '{ipc_pkg::RATIO_1, ipc_pkg::RATIO_4, ipc_pkg::RATIO_8, ipc_pkg::RATIO_16};
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        tick(3);
        rd(8'h20, 8'h04);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h00);
        rd(8'h19, 8'h00);
        wr(8'h19, 8'hFF);
        rd(8'h19, 8'h77);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        $display("Test registers done");
        // Interrupt enables, masks and sticky status
        wr(8'h19, 8'h70);
        ev(3'h1);
        tick(2);
        chk({7'h00, irq}, 8'h01);
        rd(8'h1A, 8'h01);
        rd(8'h1A, 8'h00);
        chk({7'h00, irq}, 8'h00);
        ev(3'h6);
        rd(8'h1A, 8'h06);
        wr(8'h19, 8'h77);
        ev(3'h7);
        tick(2);
        chk({7'h00, irq}, 8'h00);
        rd(8'h1A, 8'h07);
        wr(8'h19, 8'h07);
        ev(3'h7);
        rd(8'h1A, 8'h00);
        @(posedge ref_clk_in) leg <= 1'b1;
        tick(2);
        rd(8'h1A, 8'h10);
        @(posedge ref_clk_in) leg <= 1'b0;
        $display("Test interrupts done");
        // User pins
        wr(8'h1F, 8'hF0);
        pin(4'h8);
        chk({7'h00, irq}, 8'h01);
        rd(8'h1C, 8'h08);
        wr(8'h1F, 8'hF8);
        rd(8'h1F, 8'hF8);
        pin(4'h8);
        chk({7'h00, irq}, 8'h00);
        rd(8'h1C, 8'h08);
        wr(8'h1F, 8'h00);
        pin(4'hF);
        rd(8'h1C, 8'h00);
        $display("Test user pins done");
        // Low-power modes, refresh kind and clock divide
        wr(8'h20, 8'hD0);
        tick(5);
        chk({stby, slp, sref, div}, {3'h0, ipc_pkg::RATIO_1});
        @(posedge ref_clk_in) pd_n <= 1'b0;
        tick(6);
        chk({stby, slp, sref, div}, {3'h3, ipc_pkg::RATIO_4});
        chk({7'h00, pal}, 8'h01);
        for (c = 0; c < 4; c++) begin
            wr(8'h20, 8'hC0 | 8'(c << 4));
            tick(4);
            chk({3'h0, div}, {3'h0, ratio[c]});
        end
        wr(8'h20, 8'h30);
        tick(4);
        chk({stby, slp, sref, div}, {3'h4, ipc_pkg::RATIO_1});
        @(posedge ref_clk_in) pd_n <= 1'b1;
        tick(6);
        chk({stby, slp, pal, div}, {3'h0, ipc_pkg::RATIO_1});
        $display("Test power modes done");
        // Pin group tri-states: {link, video, blank, panel, memory}
        wr(8'h20, 8'h00);
        tick(3);
        chk({3'h0, loe, voe, boe, poe, moe}, 8'h1F);
        wr(8'h20, 8'h08);
        tick(3);
        chk({3'h0, loe, voe, boe, poe, moe}, 8'h0F);
        wr(8'h20, 8'h00);
        @(posedge ref_clk_in) strap <= 1'b0;
        tick(5);
        chk({3'h0, loe, voe, boe, poe, moe}, 8'h0F);
        @(posedge ref_clk_in) strap <= 1'b1;
        cap <= 1'b1;
        tick(5);
        chk({3'h0, loe, voe, boe, poe, moe}, 8'h17);
        @(posedge ref_clk_in) cap <= 1'b0;
        wr(8'h20, 8'h02);
        tick(3);
        chk({3'h0, loe, voe, boe, poe, moe}, 8'h1D);
        wr(8'h20, 8'h01);
        tick(3);
        chk({3'h0, loe, voe, boe, poe, moe}, 8'h1E);
        wr(8'h20, 8'h04);
        tick(3);
        chk({3'h0, loe, voe, boe, poe, moe}, 8'h13);
        $display("Test tri-states done");
        // Block disables, one bit at a time
        for (c = 0; c < 8; c++) begin
            wr(8'h21, 8'h01 << c);
            tick(3);
            chk({dac, pll, lw, lr, pal, vip, drw, vpr}, 8'h01 << c);
            rd(8'h21, 8'h01 << c);
        end
        $display("Test block disables done");
        // Sync states and direct panel pins
        for (c = 0; c < 4; c++) begin
            wr(8'h22, 8'(c << 4));
            tick(2);
            chk({6'h00, vs, hs}, 8'(c));
        end
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h3F);
        tick(2);
        chk({6'h00, pe, pb}, 8'h03);
        wr(8'h22, 8'h08);
        tick(2);
        chk({6'h00, pe, pb}, 8'h02);
        @(posedge ref_clk_in) seq_en <= 1'b1;
        pctl <= 8'h02;
        tick(3);
        chk({6'h00, pe, pb}, 8'h01);
        $display("Test panel control done");
        end_sim();
    end
endmodule : test_ipc_regs
`default_nettype wire
